// file: core/hcp_host_cpu_port.sv
// Host processor port: two-mode synchronous eight-bit host interface
`timescale 1ns/1ns
`default_nettype none

module hcp_host_cpu_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_second_in,
  input wire logic host_bus_clk,
  input wire logic xfer_strobe_in_n,
  input wire logic addr_latch_in,
  input wire logic rd_wr_dir_in,
  input wire logic [hcp_pkg::HCP_ADDR_W-1:0] addr_in,
  input wire logic [hcp_pkg::HCP_BE_W-1:0] byte_enable_in,
  input wire logic [hcp_pkg::HCP_DATA_W-1:0] data_in,
  output logic [hcp_pkg::HCP_DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic xfer_ack_out,
  output logic burst_inhibit_out,
  output logic host_irq_n,
  output logic user_req,
  output hcp_pkg::hcp_req_t user_req_info,
  input wire logic user_ack,
  input wire logic [hcp_pkg::HCP_DATA_W-1:0] user_rdata,
  input wire logic irq_event
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hcp_pkg::hcp_pins_t pins_raw;
  hcp_pkg::hcp_pins_t pins_s;
  logic bus_clk_prev_q;
  logic host_edge;
  logic is_write;
  logic [hcp_pkg::HCP_ADDR_W-1:0] mux_addr;

  assign pins_raw = '{
    mode_second: mode_second_in,
    bus_clk: host_bus_clk,
    strobe_n: xfer_strobe_in_n,
    addr_latch: addr_latch_in,
    rd_wr_dir: rd_wr_dir_in,
    addr: addr_in,
    byte_en: byte_enable_in,
    data: data_in
  };

  hcp_sync #(
    .WIDTH($bits(hcp_pkg::hcp_pins_t))
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ****************************************
  // Host clock edge detect
  // ****************************************
  // The host clock is far slower than clk_sys, so one edge per host period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_clk_prev_q <= 1'h0;
    end else begin
      bus_clk_prev_q <= pins_s.bus_clk;
    end
  end

  assign host_edge = pins_s.bus_clk & ~bus_clk_prev_q;

  // Direction decode differs by mode
  assign is_write = pins_s.mode_second ? (pins_s.rd_wr_dir == hcp_pkg::HCP_RW_WRITE_SECOND)
                                       : (pins_s.rd_wr_dir == hcp_pkg::HCP_RW_WRITE_FIRST);

  // Second mode: upper address pins unused, byte enables form the low bits
  assign mux_addr = {pins_s.data[hcp_pkg::HCP_MUX_ADDR_LSB +: 3], pins_s.byte_en};

  // ****************************************
  // Transfer sequencer
  // ****************************************
  hcp_pkg::hcp_state_t state_q;
  logic [hcp_pkg::HCP_ADDR_W-1:0] latched_addr_q;
  logic ack_active;
  logic ack_done;
  logic [2:0] settle_q;

  // Synchroniser depth plus the ack flop and one cycle of margin
  localparam logic [2:0] ACK_SETTLE = 3'(hcp_pkg::HCP_SYNC_STAGES + 2);

  // Address latch for the multiplexed mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latched_addr_q <= '0;
    end else if (host_edge && pins_s.mode_second && pins_s.addr_latch) begin
      latched_addr_q <= mux_addr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= hcp_pkg::HCP_ST_IDLE;
      user_req <= 1'h0;
      user_req_info <= '0;
      data_out <= '0;
      data_oe_n <= hcp_pkg::HCP_OE_OFF_N;
    end else begin
      user_req <= 1'h0;
      case (state_q)
        hcp_pkg::HCP_ST_IDLE: begin
          data_oe_n <= hcp_pkg::HCP_OE_OFF_N;
          if (host_edge && !pins_s.strobe_n) begin
            user_req_info.wr <= is_write;
            if (pins_s.mode_second) begin
              // Latch enable in the same cycle as the strobe wins over the held address
              user_req_info.addr <= pins_s.addr_latch ? mux_addr : latched_addr_q;
            end else begin
              user_req_info.addr <= pins_s.addr;
            end
            if (is_write) begin
              state_q <= hcp_hcp_st(hcp_pkg::HCP_ST_WDATA);
            end else begin
              user_req <= 1'h1;
              state_q <= hcp_pkg::HCP_ST_USER;
            end
          end
        end
        hcp_pkg::HCP_ST_WDATA: begin
          // Write data is taken on the host edge after the strobe
          if (host_edge) begin
            user_req_info.wdata <= pins_s.data;
            user_req <= 1'h1;
            state_q <= hcp_pkg::HCP_ST_USER;
          end
        end
        hcp_pkg::HCP_ST_USER: begin
          if (user_ack) begin
            if (!user_req_info.wr) begin
              data_out <= user_rdata;
              data_oe_n <= hcp_pkg::HCP_OE_ON_N;
            end
            state_q <= hcp_pkg::HCP_ST_ACK;
          end
        end
        hcp_pkg::HCP_ST_ACK: begin
          // Acknowledge stands until the host samples it on its next edge
          if (ack_done) begin
            data_oe_n <= hcp_pkg::HCP_OE_OFF_N;
            state_q <= hcp_pkg::HCP_ST_IDLE;
          end
        end
        default: begin
          state_q <= hcp_pkg::HCP_ST_IDLE;
          data_oe_n <= hcp_pkg::HCP_OE_OFF_N;
        end
      endcase
    end
  end

  function automatic hcp_pkg::hcp_state_t hcp_hcp_st(input hcp_pkg::hcp_state_t s);
    hcp_hcp_st = s;
  endfunction : hcp_hcp_st

  assign ack_active = (state_q == hcp_pkg::HCP_ST_ACK);

  // ****************************************
  // Acknowledge settle count
  // ****************************************
  // A host rise seen within the synchroniser delay of the ack flop predates
  // the ack at the pin; ending on it would drop an ack the host never saw
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_q <= '0;
    end else if (!ack_active) begin
      settle_q <= ACK_SETTLE;
    end else if (settle_q != 3'h0) begin
      settle_q <= settle_q - 3'h1;
    end
  end

  assign ack_done = ack_active && host_edge && (settle_q == 3'h0);

  // ****************************************
  // Mode-dependent handshake outputs
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_ack_out <= hcp_pkg::HCP_ACK_IDLE_FIRST;
      burst_inhibit_out <= hcp_pkg::HCP_BI_SECOND;
    end else if (pins_s.mode_second) begin
      xfer_ack_out <= ~ack_active;
      burst_inhibit_out <= hcp_pkg::HCP_BI_SECOND;
    end else begin
      xfer_ack_out <= ack_active;
      burst_inhibit_out <= hcp_pkg::HCP_BI_FIRST;
    end
  end

  // ****************************************
  // Interrupt request
  // ****************************************
  logic irq_clear;

  assign irq_clear = ack_done && user_req_info.wr
                     && (user_req_info.addr == hcp_pkg::HCP_IRQ_CLR_ADDR);

  // A new event in the clearing cycle keeps the request asserted
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_irq_n <= hcp_pkg::HCP_IRQ_IDLE_N;
    end else if (irq_event) begin
      host_irq_n <= 1'h0;
    end else if (irq_clear) begin
      host_irq_n <= 1'h1;
    end
  end

endmodule : hcp_host_cpu_port

`default_nettype wire

// file: shared/hcp_pkg.sv
// Shared constants and types for the host processor port
package hcp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned HCP_ADDR_W = 5;
  localparam int unsigned HCP_DATA_W = 8;
  localparam int unsigned HCP_BE_W = 2;

  // ****************************************
  // Reset values, fixed levels and synchroniser depth
  // ****************************************
  localparam logic HCP_IRQ_IDLE_N = 1'h1;
  localparam logic HCP_OE_OFF_N = 1'h1;
  localparam logic HCP_OE_ON_N = 1'h0;
  localparam logic HCP_ACK_IDLE_FIRST = 1'h0;
  localparam logic HCP_ACK_IDLE_SECOND = 1'h1;
  localparam logic HCP_BI_FIRST = 1'h1;
  localparam logic HCP_BI_SECOND = 1'h0;
  localparam int unsigned HCP_SYNC_STAGES = 2;

  // Direction pin levels per mode
  localparam logic HCP_RW_WRITE_FIRST = 1'h0;
  localparam logic HCP_RW_WRITE_SECOND = 1'h1;

  // Field positions in the second-mode address phase
  localparam int unsigned HCP_MUX_ADDR_LSB = 2;

  // Address that clears the interrupt request when written
  localparam logic [HCP_ADDR_W-1:0] HCP_IRQ_CLR_ADDR = 5'h1F;

  // ****************************************
  // Transfer state, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    HCP_ST_IDLE = 4'h1,
    HCP_ST_WDATA = 4'h2,
    HCP_ST_USER = 4'h4,
    HCP_ST_ACK = 4'h8
  } hcp_state_t;

  // Host pins gathered for synchronising
  typedef struct packed {
    logic mode_second;
    logic bus_clk;
    logic strobe_n;
    logic addr_latch;
    logic rd_wr_dir;
    logic [HCP_ADDR_W-1:0] addr;
    logic [HCP_BE_W-1:0] byte_en;
    logic [HCP_DATA_W-1:0] data;
  } hcp_pins_t;

  // Request toward the user logic
  typedef struct packed {
    logic wr;
    logic [HCP_ADDR_W-1:0] addr;
    logic [HCP_DATA_W-1:0] wdata;
  } hcp_req_t;

endpackage : hcp_pkg

// file: core/hcp_sync.sv
// Two-stage synchroniser for a vector of host pins
`timescale 1ns/1ns
`default_nettype none

module hcp_sync #(
  parameter int unsigned WIDTH = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : hcp_sync

`default_nettype wire

// file: verification/hcp_port_asserts.sv
// Checker for the host processor port
`timescale 1ns/1ns
`default_nettype none
module hcp_port_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_second_in,
  input wire logic xfer_ack_out,
  input wire logic burst_inhibit_out,
  input wire logic host_irq_n,
  input wire logic data_oe_n,
  input wire logic [hcp_pkg::HCP_DATA_W-1:0] data_out,
  input wire logic user_req,
  input wire hcp_pkg::hcp_req_t user_req_info,
  input wire logic user_ack,
  input wire logic [hcp_pkg::HCP_DATA_W-1:0] user_rdata,
  input wire logic irq_event
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Ack level read through the mode, so one relation covers both polarities
  wire logic ack_on = mode_second_in ? !xfer_ack_out : xfer_ack_out;
  wire logic clr_w = user_req_info.wr && user_req_info.addr == hcp_pkg::HCP_IRQ_CLR_ADDR;
  sequence quiet3;
    !ack_on [*3];
  endsequence
  sequence rd_answer;
    !data_oe_n ##1 ack_on;
  endsequence
  irq_set_a: assert property (irq_event |=> !host_irq_n)
    else $error("irq not raised");
  irq_hold_a: assert property (!host_irq_n && !clr_w |=> !host_irq_n)
    else $error("irq dropped");
  bi_mode_a: assert property ($stable(mode_second_in) [*6] |->
    burst_inhibit_out == (mode_second_in ? hcp_pkg::HCP_BI_SECOND : hcp_pkg::HCP_BI_FIRST))
    else $error("burst inhibit wrong");
  ack_rise_a: assert property (user_ack |-> ##2 ack_on)
    else $error("ack late");
  ack_quiet_a: assert property (user_req |-> quiet3)
    else $error("ack early");
  rd_drive_a: assert property (user_ack && !user_req_info.wr |=>
    rd_answer and data_out == $past(user_rdata))
    else $error("read data wrong");
  wr_float_a: assert property (user_req_info.wr |-> data_oe_n)
    else $error("driven in write");
  req_pulse_a: assert property (user_req |=> !user_req [*2])
    else $error("request repeated");
endmodule : hcp_port_asserts
bind hcp_host_cpu_port hcp_port_asserts chk (.clk_sys, .rst, .mode_second_in, .xfer_ack_out,
  .burst_inhibit_out, .host_irq_n, .data_oe_n, .data_out, .user_req, .user_req_info,
  .user_ack, .user_rdata, .irq_event);
`default_nettype wire

// file: verification/hcp_host_model.sv
// Host bus model driving the port's host-side pins
`timescale 1ns/1ns
`default_nettype none
module hcp_host_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic wr,
  input wire logic mode2,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] dout,
  output logic hclk,
  output logic strb_n,
  output logic ale,
  output logic rw,
  output logic [4:0] apin,
  output logic [1:0] be,
  output logic [7:0] dpin,
  output logic done,
  output logic [7:0] rdata
);
  logic [2:0] ph;
  logic [1:0] div;
  wire logic act = mode2 ? !ack : ack;
  wire logic fall = div == 2'h3 && hclk;
  wire logic rise = div == 2'h3 && !hclk;
  wire logic wl = mode2 ? hcp_pkg::HCP_RW_WRITE_SECOND : hcp_pkg::HCP_RW_WRITE_FIRST;
  initial begin
    {hclk, strb_n, ale, rw, done, ph, div} = 10'h140;
    {apin, be, dpin, rdata} = '0;
  end
  always @(posedge clk_sys) begin
    done <= 1'h0;
    // Clock stands still between transfers
    if (ph != 3'h0) div <= div + 2'h1;
    if (ph != 3'h0 && div == 2'h3) hclk <= ~hclk;
    case (ph)
      3'h0: if (go) begin
        ph <= 3'h1;
        strb_n <= 1'h0;
        ale <= mode2;
        rw <= wr ? wl : !wl;
        apin <= mode2 ? ~addr : addr;
        be <= mode2 ? addr[1:0] : ~addr[1:0];
        dpin <= mode2 ? {~wdata[7:5], addr[4:2], ~wdata[1:0]} : ~wdata;
      end
      3'h1: if (fall) begin
        ph <= 3'h2;
        strb_n <= 1'h1;
        ale <= 1'h0;
        dpin <= wdata;
      end
      // Ack and read data are taken only at host clock rises, as a real host would
      3'h2: if (rise && act) begin
        ph <= 3'h3;
        rdata <= dout;
      end else if (fall) begin
        // Released bus flips to the inverse at each fall, so every second fall brings back the write data
        dpin <= ~dpin;
      end
      3'h3: if (!act && !hclk && div != 2'h3) begin
        ph <= 3'h0;
        done <= 1'h1;
      end
      default: ph <= 3'h0;
    endcase
  end
endmodule : hcp_host_model
`default_nettype wire

// file: verification/hcp_host_cpu_port_tb.sv
// Self-checking bench for the host processor port
`timescale 1ns/1ns
`default_nettype none
module hcp_host_cpu_port_tb;
  logic clk_sys, rst, mode2, go, wr, user_ack, irq_event;
  logic [4:0] addr;
  logic [7:0] wdata, user_rdata;
  logic [15:0] seed;
  wire logic hclk, strb_n, ale, rw, done, oe_n, ack, bi, irq_n, user_req;
  wire logic [4:0] apin;
  wire logic [1:0] be;
  wire logic [7:0] dpin, dout, rdata;
  wire hcp_pkg::hcp_req_t info;
  hcp_pkg::hcp_req_t exp_q[$];
  hcp_pkg::hcp_req_t got;
  int fails, cmp_count;
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(string what, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (e !== s) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic close_out;
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic xfer(logic w, logic [4:0] a);
    int n;
    seed = lfsr(seed);
    exp_q.push_back('{w, a, seed[7:0]});
    wr <= w;
    addr <= a;
    wdata <= seed[7:0];
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 500) fails++;
    if (!w) check("read data", user_rdata, rdata);
  endtask : xfer
  hcp_host_cpu_port uut (.clk_sys, .rst, .mode_second_in(mode2), .host_bus_clk(hclk),
    .xfer_strobe_in_n(strb_n), .addr_latch_in(ale), .rd_wr_dir_in(rw), .addr_in(apin),
    .byte_enable_in(be), .data_in(dpin), .data_out(dout), .data_oe_n(oe_n),
    .xfer_ack_out(ack), .burst_inhibit_out(bi), .host_irq_n(irq_n), .user_req,
    .user_req_info(info), .user_ack, .user_rdata, .irq_event);
  hcp_host_model host (.clk_sys, .go, .wr, .mode2, .addr, .wdata, .ack, .dout, .hclk,
    .strb_n, .ale, .rw, .apin, .be, .dpin, .done, .rdata);
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
  always @(posedge clk_sys) if (user_req === 1'h1 && exp_q.size() > 0) begin
    got = exp_q.pop_front();
    check("req dir", got.wr, info.wr);
    check("req addr", got.addr, info.addr);
    if (got.wr) check("req wdata", got.wdata, info.wdata);
    repeat (seed[1:0]) @(posedge clk_sys);
    user_ack <= 1'h1;
    user_rdata <= seed[15:8];
    @(posedge clk_sys);
    user_ack <= 1'h0;
  end
  initial begin
    {rst, mode2, go, wr, user_ack, irq_event, addr, wdata, user_rdata} = 27'h4000000;
    {fails, cmp_count, seed} = {64'h0, 16'h9BF4};
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    for (int m = 0; m < 2; m++) begin
      mode2 <= m[0];
      repeat (8) @(posedge clk_sys);
      check("burst", m ? hcp_pkg::HCP_BI_SECOND : hcp_pkg::HCP_BI_FIRST, bi);
      check("ack idle", m ? 1'h1 : 1'h0, ack);
      irq_event <= 1'h1;
      @(posedge clk_sys);
      irq_event <= 1'h0;
      @(posedge clk_sys);
      check("irq set", 8'h0, irq_n);
      for (int i = 0; i < 6; i++) xfer(i[0], seed[12:8] & 5'h1E);
      check("irq held", 8'h0, irq_n);
      xfer(1'h1, hcp_pkg::HCP_IRQ_CLR_ADDR);
      repeat (2) @(posedge clk_sys);
      check("irq clear", 8'h1, irq_n);
    end
    close_out();
  end
endmodule : hcp_host_cpu_port_tb
`default_nettype wire
